// File: dpc_pkg.sv
// datapath configuration register: shared constants and carrier types
// assumes a single pclk domain and an apb master on the register side
package dpc_pkg;

   // register index as printed; the apb byte address is four times it
   localparam logic [7:0] DPC_CFG_IDX = 8'h22;
   localparam logic [11:0] DPC_CFG_ADDR = {2'h0, DPC_CFG_IDX, 2'h0};
   localparam logic [7:0] DPC_CFG_RST = 8'h00;

   // field positions
   localparam int DPC_BIT_LOCK = 7;
   localparam int DPC_BIT_PASS = 6;
   localparam int DPC_BIT_DEPOL = 5;
   localparam int DPC_BIT_REGEN = 4;
   localparam int DPC_BIT_4CH_OVR = 3;
   localparam int DPC_BIT_18BIT = 2;
   localparam int DPC_BIT_INBAND = 1;
   localparam int DPC_BIT_4CH_EN = 0;

   // width of the part the forward channel may load
   localparam int DPC_FC_W = 7;

   // synchroniser depth for the data enable pin
   localparam int DPC_SYNC_STAGES = 2;

   // register layout, msb first
   typedef struct packed {
      logic forward_load_lock;
      logic pixel_pass_ungated;
      logic data_enable_polarity;
      logic audio_repeater_regen;
      logic four_ch_override;
      logic video_18bit;
      logic audio_inband;
      logic four_ch_enable;
   } dpc_cfg_t;

   // forward channel configuration update
   typedef struct packed {
      logic valid;
      logic [DPC_FC_W-1:0] data;
   } dpc_fc_t;

   // steering outputs toward the video and audio path
   typedef struct packed {
      logic pixel_forward;
      logic cp_encrypt_en;
      logic audio_pkt_en;
      logic audio_on_pixel;
      logic audio_on_repeater;
      logic four_ch_active;
      logic video_18bit;
      logic audio_inband;
   } dpc_path_t;

endpackage : dpc_pkg

// File: dpc_sync.sv
// dpc_sync: multi-stage level synchroniser into pclk
// assumes the input is a slow level from a pin; pulses may be missed
`timescale 1ns/1ps
module dpc_sync
   import dpc_pkg::*;
#(
   parameter int W = 1,
   parameter int STAGES = DPC_SYNC_STAGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [STAGES-1:0][W-1:0] stage_q;

   // first stage feeds only the next stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= '0;
      end else begin
         stage_q <= {stage_q[STAGES-2:0], async_i};
      end
   end

   assign sync_o = stage_q[STAGES-1];

endmodule : dpc_sync

// File: dpc_ctrl.sv
// dpc_ctrl: datapath configuration register with apb access,
// forward channel loading and steering of the received video/audio path
// assumes apb master and forward channel logic on pclk; de pin is asynchronous
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps

// Function
// - lock bit set ignores forward channel updates
// - unlocked, forward channel loads bits six to zero
// - pixel pass forwards pixels regardless of enable
// - pixel pass disables encryption, blocks audio packets
// - pixel pass ignored without peer protection support
// - polarity bit selects active low data enable
// - regen bit moves audio to repeater pins
// - override selects four channel from enable bit
// - bit two selects 18-bit versus 24-bit video
// - bit one selects in-band versus island audio
// - bit zero enables four channel audio reception
module dpc_ctrl
   import dpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dpc_fc_t fc_cfg_i,
   input wire logic peer_cp_capable_i,
   input wire logic cp_request_i,
   input wire logic de_pin_i,
   output dpc_path_t path_o
);

   typedef struct packed {
      dpc_cfg_t cfg;
      dpc_path_t path;
      logic [31:0] rdata;
   } dpc_state_t;

   dpc_state_t state_q;
   dpc_state_t state_d;
   logic de_sync;
   logic apb_access;
   logic apb_hit;
   logic sw_wr;
   logic fc_ld;
   logic pass_eff;
   logic de_active;

   dpc_sync #(
      .W(1),
      .STAGES(DPC_SYNC_STAGES)
   ) u_de_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_i(de_pin_i),
      .sync_o(de_sync)
   );

   // zero wait state slave; writes and errors act only in the access phase, read data is caught in setup
   assign apb_access = psel && penable;
   assign apb_hit = (paddr == DPC_CFG_ADDR);
   assign sw_wr = apb_access && pwrite && apb_hit && pstrb[0];
   assign fc_ld = fc_cfg_i.valid && !state_q.cfg.forward_load_lock;
   // pass only honoured when the peer can do content protection
   assign pass_eff = state_q.cfg.pixel_pass_ungated && peer_cp_capable_i;
   assign de_active = de_sync ^ state_q.cfg.data_enable_polarity;

   always_comb begin
      state_d = state_q;
      // forward channel first; a same-cycle software write wins below
      if (fc_ld) begin
         state_d.cfg[DPC_FC_W-1:0] = fc_cfg_i.data;
      end
      if (sw_wr) begin
         state_d.cfg = pwdata[7:0];
      end
      // read data caught in the setup cycle so prdata leaves a flop
      // with no wait state; state_d.cfg is what stands in the access cycle
      if (psel && !penable && !pwrite) begin
         state_d.rdata = apb_hit ? {24'h000000, state_d.cfg} : 32'h00000000;
      end
      state_d.path.pixel_forward = pass_eff || de_active;
      state_d.path.cp_encrypt_en = cp_request_i && !pass_eff;
      state_d.path.audio_pkt_en = !pass_eff;
      state_d.path.audio_on_pixel = !pass_eff && !state_q.cfg.audio_repeater_regen;
      state_d.path.audio_on_repeater = state_q.cfg.audio_repeater_regen;
      // override off forces four channel off whatever the enable says
      state_d.path.four_ch_active = state_q.cfg.four_ch_override
         && state_q.cfg.four_ch_enable;
      state_d.path.video_18bit = state_q.cfg.video_18bit;
      state_d.path.audio_inband = state_q.cfg.audio_inband;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign pready = 1'b1;
   assign pslverr = apb_access && !apb_hit;
   assign prdata = state_q.rdata;
   assign path_o = state_q.path;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_lock_holds;
      fc_cfg_i.valid && state_q.cfg.forward_load_lock && !sw_wr
         |=> state_q.cfg == $past(state_q.cfg);
   endproperty
   a_lock_holds: assert property (p_lock_holds)
      else $error("forward load changed a locked register");

   property p_fc_loads;
      fc_cfg_i.valid && !state_q.cfg.forward_load_lock && !sw_wr
         |=> state_q.cfg[DPC_FC_W-1:0] == $past(fc_cfg_i.data)
             && state_q.cfg.forward_load_lock == 1'b0;
   endproperty
   a_fc_loads: assert property (p_fc_loads)
      else $error("forward load not applied to low seven bits");

   property p_pass_forwards;
      state_q.cfg.pixel_pass_ungated && peer_cp_capable_i |=> path_o.pixel_forward;
   endproperty
   a_pass_forwards: assert property (p_pass_forwards)
      else $error("ungated pass did not forward pixels");

   property p_pass_blocks;
      state_q.cfg.pixel_pass_ungated && peer_cp_capable_i
         |=> !path_o.cp_encrypt_en && !path_o.audio_pkt_en && !path_o.audio_on_pixel;
   endproperty
   a_pass_blocks: assert property (p_pass_blocks)
      else $error("encryption or audio left on during ungated pass");

   property p_pass_no_peer;
      !peer_cp_capable_i
         |=> path_o.pixel_forward == ($past(de_sync) ^ $past(state_q.cfg.data_enable_polarity))
             && path_o.audio_pkt_en;
   endproperty
   a_pass_no_peer: assert property (p_pass_no_peer)
      else $error("ungated pass acted without peer support");

   property p_data_enable_polarity;
      !state_q.cfg.pixel_pass_ungated && state_q.cfg.data_enable_polarity && de_sync
         |=> !path_o.pixel_forward;
   endproperty
   a_data_enable_polarity: assert property (p_data_enable_polarity)
      else $error("inverted enable high still forwarded pixels");

   property p_regen;
      state_q.cfg.audio_repeater_regen |=> path_o.audio_on_repeater && !path_o.audio_on_pixel;
   endproperty
   a_regen: assert property (p_regen)
      else $error("repeater regeneration left audio on pixel pins");

   property p_four_ch;
      ##1 path_o.four_ch_active
         == ($past(state_q.cfg.four_ch_override) && $past(state_q.cfg.four_ch_enable));
   endproperty
   a_four_ch: assert property (p_four_ch)
      else $error("four channel enable wrong");

   property p_depth;
      $changed(state_q.cfg.video_18bit) |=> path_o.video_18bit == $past(state_q.cfg.video_18bit);
   endproperty
   a_depth: assert property (p_depth)
      else $error("colour depth output not following register");

   property p_transport;
      $changed(state_q.cfg.audio_inband) |=> path_o.audio_inband == $past(state_q.cfg.audio_inband);
   endproperty
   a_transport: assert property (p_transport)
      else $error("audio transport output not following register");

   property p_reset_zero;
      @(posedge pclk) disable iff (1'b0) !presetn |-> state_q.cfg == DPC_CFG_RST;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("register not zero in reset");

   property p_sw_write;
      sw_wr |=> state_q.cfg == $past(pwdata[7:0]);
   endproperty
   a_sw_write: assert property (p_sw_write)
      else $error("software write not stored");

   property p_err_miss;
      psel && penable && !apb_hit |-> pslverr;
   endproperty
   a_err_miss: assert property (p_err_miss)
      else $error("unmapped access gave no error");

   property p_err_hit;
      psel && penable && apb_hit |-> !pslverr;
   endproperty
   a_err_hit: assert property (p_err_hit)
      else $error("error flagged on the mapped register");

   property p_rd_hit;
      psel && penable && !pwrite && apb_hit |-> prdata == {24'h000000, state_q.cfg};
   endproperty
   a_rd_hit: assert property (p_rd_hit)
      else $error("read data differs from register");

   property p_rd_miss;
      psel && penable && !pwrite && !apb_hit |-> prdata == 32'h00000000;
   endproperty
   a_rd_miss: assert property (p_rd_miss)
      else $error("unmapped read returned nonzero data");

   property p_rd_hold;
      !(psel && !penable && !pwrite) |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved outside a read setup");

   property p_miss_no_write;
      psel && penable && pwrite && !apb_hit && !fc_ld
         |=> state_q.cfg == $past(state_q.cfg);
   endproperty
   a_miss_no_write: assert property (p_miss_no_write)
      else $error("unmapped write changed the register");

   property p_strb_ignored;
      psel && penable && pwrite && apb_hit && !pstrb[0] && !fc_ld
         |=> state_q.cfg == $past(state_q.cfg);
   endproperty
   a_strb_ignored: assert property (p_strb_ignored)
      else $error("write without low strobe changed the register");

   property p_lock_not_loaded;
      !sw_wr
         |=> state_q.cfg.forward_load_lock == $past(state_q.cfg.forward_load_lock);
   endproperty
   a_lock_not_loaded: assert property (p_lock_not_loaded)
      else $error("lock bit changed without a software write");

   property p_encrypt_follows;
      !(state_q.cfg.pixel_pass_ungated && peer_cp_capable_i)
         |=> path_o.cp_encrypt_en == $past(cp_request_i);
   endproperty
   a_encrypt_follows: assert property (p_encrypt_follows)
      else $error("encryption not following request outside pass");

   property p_de_normal;
      !state_q.cfg.pixel_pass_ungated && !state_q.cfg.data_enable_polarity
         |=> path_o.pixel_forward == $past(de_sync);
   endproperty
   a_de_normal: assert property (p_de_normal)
      else $error("active high enable not followed");

   property p_regen_off;
      !state_q.cfg.audio_repeater_regen && !(state_q.cfg.pixel_pass_ungated && peer_cp_capable_i)
         |=> path_o.audio_on_pixel && !path_o.audio_on_repeater;
   endproperty
   a_regen_off: assert property (p_regen_off)
      else $error("audio not on pixel pins without regeneration");

   property p_four_ch_off;
      !state_q.cfg.four_ch_override |=> !path_o.four_ch_active;
   endproperty
   a_four_ch_off: assert property (p_four_ch_off)
      else $error("four channel on without override");

   property p_four_ch_en_off;
      !state_q.cfg.four_ch_enable |=> !path_o.four_ch_active;
   endproperty
   a_four_ch_en_off: assert property (p_four_ch_en_off)
      else $error("four channel on without enable");

   property p_depth_18;
      state_q.cfg.video_18bit |=> path_o.video_18bit;
   endproperty
   a_depth_18: assert property (p_depth_18)
      else $error("18-bit mode not shown");

   property p_depth_24;
      !state_q.cfg.video_18bit |=> !path_o.video_18bit;
   endproperty
   a_depth_24: assert property (p_depth_24)
      else $error("24-bit mode not shown");

   property p_inband;
      state_q.cfg.audio_inband |=> path_o.audio_inband;
   endproperty
   a_inband: assert property (p_inband)
      else $error("in-band transport not shown");

   property p_island;
      !state_q.cfg.audio_inband |=> !path_o.audio_inband;
   endproperty
   a_island: assert property (p_island)
      else $error("island transport not shown");

   property p_reset_path;
      @(posedge pclk) disable iff (1'b0) !presetn |-> path_o == '0 && prdata == 32'h00000000;
   endproperty
   a_reset_path: assert property (p_reset_path)
      else $error("outputs not zero in reset");

endmodule : dpc_ctrl

// File: dpc_fc_model.sv
// dpc_fc_model: remote serializer side, issues forward channel updates
// assumes send is a one-cycle request from the bench, all on pclk
`timescale 1ns/1ps
module dpc_fc_model
   import dpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic send,
   input wire logic [DPC_FC_W-1:0] data_in,
   output dpc_fc_t fc_o
);
   // idle data flips each cycle so a stale value never looks good
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fc_o <= '0;
      end else begin
         fc_o.valid <= send;
         fc_o.data <= send ? data_in : ~fc_o.data;
      end
   end
endmodule : dpc_fc_model

// File: tb_top.sv
// tb_top: self-checking bench for dpc_ctrl
// assumes zero or more apb wait states and the forward channel model
`timescale 1ns/1ps
module tb_top;
   import dpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, send, peer, req, de, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [DPC_FC_W-1:0] fdata;
   logic [7:0] tbl [10] = '{8'h00, 8'h40, 8'h20, 8'h60, 8'h10, 8'h09, 8'h08, 8'h01, 8'h04, 8'h02};
   dpc_fc_t fc;
   dpc_path_t path;
   int errors, n_compared;
   dpc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fc_cfg_i(fc), .peer_cp_capable_i(peer),
      .cp_request_i(req), .de_pin_i(de), .path_o(path));
   dpc_fc_model fc_u (.pclk(pclk), .presetn(presetn), .send(send), .data_in(fdata), .fc_o(fc));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("errors=%0d n_compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      forever begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic fwd(input logic [6:0] d);
      send <= 1'b1;
      fdata <= d;
      @(posedge pclk);
      send <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : fwd
   function automatic dpc_path_t exp_path(dpc_cfg_t c, logic pr, logic rq, logic d);
      logic g;
      g = c.pixel_pass_ungated & pr;
      return '{g | (d ^ c.data_enable_polarity), rq & !g, !g, !g & !c.audio_repeater_regen,
         c.audio_repeater_regen, c.four_ch_override & c.four_ch_enable, c.video_18bit,
         c.audio_inband};
   endfunction : exp_path
   task automatic t_load;
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h0);
      fwd(7'h55);
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h55);
      apb(1'b1, DPC_CFG_ADDR, 32'hFF, 4'hF);
      fwd(7'h00);
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'hFF);
      apb(1'b1, DPC_CFG_ADDR, 32'h00, 4'hF);
      fwd(7'h2A);
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h2A);
   endtask : t_load
   task automatic t_unmapped;
      apb(1'b1, 12'h08C, 32'hFF, 4'hF);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 12'h08C, 32'h0, 4'hF);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, DPC_CFG_ADDR, 32'h7F, 4'h0);
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h2A);
      chk({31'h0, er}, 32'h0);
   endtask : t_unmapped
   task automatic t_reset;
      apb(1'b1, DPC_CFG_ADDR, 32'h7F, 4'hF);
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h7F);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({24'h0, path}, 32'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, DPC_CFG_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h0);
   endtask : t_reset
   task automatic t_path;
      for (int i = 0; i < 10; i++) begin
         for (int k = 0; k < 4; k++) begin
            peer <= k[0];
            de <= k[1];
            req <= k[0] ~^ k[1];
            apb(1'b1, DPC_CFG_ADDR, {24'h0, tbl[i]}, 4'hF);
            repeat (5) @(posedge pclk);
            chk({24'h0, path}, {24'h0, exp_path(tbl[i], k[0], req, k[1])});
         end
      end
   endtask : t_path
   initial begin
      presetn <= 1'b0;
      {psel, penable, pwrite, send, peer, de} = '0;
      req = 1'b1;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      fdata = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_load;
      t_unmapped;
      t_path;
      t_reset;
      close_out;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      close_out;
   end
endmodule : tb_top
